// ===== rtl/program_sequencer_stack.sv
`timescale 1ns/1ns
module program_sequencer_stack (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // operation request from decode
  input wire logic op_valid,
  input seq_pkg::seq_op_t op,
  input wire logic [13:0] jump_target,
  input wire logic [2:0] step_bytes,
  output logic op_ready,
  // flags from alu
  input seq_pkg::flags_t flags_in,
  output seq_pkg::flags_t flags_out,
  // stack pointer load and index register
  input wire logic sp_load,
  input wire logic [7:0] accumulator,
  input wire logic index_we,
  input wire logic [7:0] index_wdata,
  input wire logic [7:0] index_base,
  output logic [7:0] index_value,
  output logic [7:0] index_addr,
  // data ram port, read data valid next cycle
  output seq_pkg::ram_req_t ram_req,
  input wire logic [7:0] ram_rdata,
  // program memory fetch and status
  output logic [13:0] fetch_pointer,
  output logic [7:0] return_stack_pointer,
  output logic int_enable
);
  typedef enum logic [2:0] {
    st_idle, st_push2, st_pop1, st_pop2, st_pop3
  } state_t;

  state_t state_q;
  logic [13:0] pc_q;
  logic [7:0] lo_save_q;
  logic [7:0] push_lo_q;
  logic is_interrupt_return_op_q;
  logic ie_q;
  seq_pkg::flags_t flags_q;
  logic sp_inc;
  logic sp_dec;
  logic [7:0] sp;
  logic take;
  seq_pkg::ram_req_t req_d;
  seq_pkg::ram_req_t req_q;

  assign op_ready = (state_q == st_idle);
  assign take = op_valid && op_ready;
  assign fetch_pointer = pc_q;
  assign return_stack_pointer = sp;
  assign int_enable = ie_q;
  assign flags_out = flags_q;
  assign ram_req = req_q;

  ret_stack_ptr u_sp (
    .clock(clock),
    .rstn(rstn),
    .inc(sp_inc),
    .dec(sp_dec),
    .load(sp_load && op_ready),
    .load_val(accumulator),
    .sp(sp)
  );

  index_reg u_idx (
    .clock(clock),
    .rstn(rstn),
    .we(index_we),
    .wdata(index_wdata),
    .base(index_base),
    .value(index_value),
    .eff_addr(index_addr)
  );

  // sequencing state; multi-byte stack ops block new requests
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_q <= st_idle;
      is_interrupt_return_op_q <= 1'b0;
    end else begin
      unique case (state_q)
        st_idle: begin
          if (take && (op == seq_pkg::op_call || op == seq_pkg::op_irq)) begin
            state_q <= st_push2;
          end else if (take && (op == seq_pkg::op_ret || op == seq_pkg::op_interrupt_return_op)) begin
            state_q <= st_pop1;
            is_interrupt_return_op_q <= (op == seq_pkg::op_interrupt_return_op);
          end
        end
        st_push2: state_q <= st_idle;
        st_pop1: state_q <= st_pop2;
        st_pop2: state_q <= st_pop3;
        st_pop3: state_q <= st_idle;
      endcase
    end
  end

  // stack pointer moves one byte per memory access
  always_comb begin
    sp_inc = 1'b0;
    sp_dec = 1'b0;
    req_d = '0;
    unique case (state_q)
      st_idle: begin
        if (take && (op == seq_pkg::op_call || op == seq_pkg::op_irq)) begin
          req_d.we = 1'b1;
          req_d.addr = sp;
          req_d.wdata = {flags_in.carry, flags_in.zero, pc_q[13:8]};
          sp_inc = 1'b1;
        end else if (take && (op == seq_pkg::op_ret || op == seq_pkg::op_interrupt_return_op)) begin
          // read leaves with the decrement, so the byte returns while still busy
          req_d.re = 1'b1;
          req_d.addr = sp - seq_pkg::one_b;
          sp_dec = 1'b1;
        end
      end
      st_push2: begin
        req_d.we = 1'b1;
        req_d.addr = sp;
        req_d.wdata = push_lo_q;
        sp_inc = 1'b1;
      end
      st_pop1: begin
        req_d.re = 1'b1;
        req_d.addr = sp - seq_pkg::one_b;
        sp_dec = 1'b1;
      end
      st_pop2: begin
        // second byte stands on the read data now, first byte follows next cycle
        req_d = '0;
      end
      st_pop3: begin
        req_d = '0;
      end
    endcase
  end

  // ram request register, data outputs from flops
  always_ff @(posedge clock) begin
    if (!rstn) begin
      req_q <= '0;
    end else begin
      req_q <= req_d;
    end
  end

  // fetch pointer; the saved pointer is the address of the next instruction
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pc_q <= seq_pkg::pc_reset;
      lo_save_q <= 8'h00;
    end else if (take) begin
      unique case (op)
        seq_pkg::op_step: pc_q[7:0] <= pc_q[7:0] + {5'h00, step_bytes};
        seq_pkg::op_page: pc_q[13:8] <= pc_q[13:8] + seq_pkg::one_p;
        seq_pkg::op_call: pc_q <= jump_target;
        seq_pkg::op_irq: pc_q <= jump_target;
        seq_pkg::op_jump: pc_q <= jump_target;
        default: pc_q <= pc_q;
      endcase
    end else if (state_q == st_pop2) begin
      lo_save_q <= ram_rdata; // second byte popped first
    end else if (state_q == st_pop3) begin
      pc_q <= {ram_rdata[5:0], lo_save_q};
    end
  end

  // low byte of the pointer before the call; the pointer jumps at take,
  // so without this copy the second byte would carry the target instead
  always_ff @(posedge clock) begin
    if (!rstn) begin
      push_lo_q <= 8'h00;
    end else if (take && (op == seq_pkg::op_call || op == seq_pkg::op_irq)) begin
      push_lo_q <= pc_q[7:0];
    end
  end

  // flags restored only on interrupt return
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flags_q <= '0;
    end else if (state_q == st_pop3 && is_interrupt_return_op_q) begin
      flags_q.carry <= ram_rdata[seq_pkg::b1_carry];
      flags_q.zero <= ram_rdata[seq_pkg::b1_zero];
    end else if (state_q == st_idle) begin
      flags_q <= flags_in;
    end
  end

  // interrupt enable: off on entry, on after the restore completes
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ie_q <= 1'b0;
    end else if (take && op == seq_pkg::op_irq) begin
      ie_q <= 1'b0;
    end else if (state_q == st_pop3 && is_interrupt_return_op_q) begin
      ie_q <= 1'b1;
    end
  end

  // reset values
  reset_pc_a: assert property (@(posedge clock) !rstn |=> pc_q == seq_pkg::pc_reset && sp == seq_pkg::sp_reset)
    else $error("reset state wrong");
  page_step_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_step |=> pc_q[13:8] == $past(pc_q[13:8]))
    else $error("step touched page");
  page_adv_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_page |=> pc_q[13:8] == $past(pc_q[13:8]) + 6'h01)
    else $error("page advance wrong");
  push_two_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_call |=> req_q.we ##1 req_q.we ##0 sp == $past(sp, 2) + 8'h02)
    else $error("push pair wrong");
  pop_two_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_ret |=> ##1 sp == $past(sp, 2) - 8'h02)
    else $error("pop pair wrong");
  ret_flags_a: assert property (@(posedge clock) disable iff (!rstn)
    state_q == st_pop3 && !is_interrupt_return_op_q |=> flags_q == $past(flags_q))
    else $error("ret changed flags");
  irq_off_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_irq |=> !ie_q)
    else $error("irq left enabled");
  interrupt_return_op_on_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_interrupt_return_op |=> ##3 ie_q)
    else $error("interrupt_return_op not re-enabled");
  sp_load_a: assert property (@(posedge clock) disable iff (!rstn)
    sp_load && op_ready |=> sp == $past(accumulator))
    else $error("sp load failed");
  // state right after reset besides the pointers
  reset_misc_a: assert property (@(posedge clock) !rstn |=> flags_q == '0 && !ie_q && req_q == '0)
    else $error("reset misc state wrong");
  // in-page stepping and paging
  step_low_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_step |=> pc_q[7:0] == $past(pc_q[7:0]) + {5'h00, $past(step_bytes)})
    else $error("step low byte wrong");
  page_low_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_page |=> pc_q[7:0] == $past(pc_q[7:0]))
    else $error("page advance moved low byte");
  // call and interrupt entry load the target
  call_target_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_call |=> pc_q == $past(jump_target))
    else $error("call target wrong");
  irq_target_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_irq |=> pc_q == $past(jump_target))
    else $error("irq vector wrong");
  // push order and contents of the saved pair
  push_addr_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (op == seq_pkg::op_call || op == seq_pkg::op_irq) |=> req_q.we && req_q.addr == $past(sp))
    else $error("first push address wrong");
  push_byte1_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (op == seq_pkg::op_call || op == seq_pkg::op_irq)
    |=> req_q.wdata == {$past(flags_in.carry), $past(flags_in.zero), $past(pc_q[13:8])})
    else $error("first saved byte wrong");
  push_byte2_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (op == seq_pkg::op_call || op == seq_pkg::op_irq) |=> ##1 req_q.we && req_q.wdata == $past(pc_q[7:0], 2))
    else $error("second saved byte wrong");
  push2_addr_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (op == seq_pkg::op_call || op == seq_pkg::op_irq) |=> ##1 req_q.addr == $past(sp, 2) + 8'h01)
    else $error("second push address wrong");
  irq_sp_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_irq |=> ##1 sp == $past(sp, 2) + 8'h02)
    else $error("irq stack pointer wrong");
  // pop order: decrement, read second byte, decrement, read first byte
  pop_addr_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (op == seq_pkg::op_ret || op == seq_pkg::op_interrupt_return_op) |=> req_q.re && req_q.addr == $past(sp) - 8'h01)
    else $error("first pop address wrong");
  pop2_addr_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (op == seq_pkg::op_ret || op == seq_pkg::op_interrupt_return_op) |=> ##1 req_q.re && req_q.addr == $past(sp, 2) - 8'h02)
    else $error("second pop address wrong");
  pop_no_write_a: assert property (@(posedge clock) disable iff (!rstn)
    take && (op == seq_pkg::op_ret || op == seq_pkg::op_interrupt_return_op) |=> !req_q.we ##1 !req_q.we)
    else $error("pop wrote ram");
  interrupt_return_op_sp_a: assert property (@(posedge clock) disable iff (!rstn)
    take && op == seq_pkg::op_interrupt_return_op |=> ##1 sp == $past(sp, 2) - 8'h02)
    else $error("interrupt_return_op stack pointer wrong");
  interrupt_return_op_flags_a: assert property (@(posedge clock) disable iff (!rstn)
    state_q == st_pop3 && is_interrupt_return_op_q
    |=> flags_q == {$past(ram_rdata[seq_pkg::b1_carry]), $past(ram_rdata[seq_pkg::b1_zero])})
    else $error("interrupt_return_op flags not restored");
  ret_keeps_ie_a: assert property (@(posedge clock) disable iff (!rstn)
    state_q == st_pop3 && !is_interrupt_return_op_q |=> ie_q == $past(ie_q))
    else $error("ret changed int enable");
  // quiet cycles leave state alone, and an index write loads the index register
  busy_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    !op_ready && state_q != st_pop3 |=> pc_q == $past(pc_q))
    else $error("pointer moved while busy");
  idle_quiet_a: assert property (@(posedge clock) disable iff (!rstn)
    state_q == st_idle && !take |=> !req_q.we && !req_q.re)
    else $error("stray ram access");
  sp_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    op_ready && !take && !sp_load |=> sp == $past(sp))
    else $error("stack pointer drifted");
  ie_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    !(take && op == seq_pkg::op_irq) && !(state_q == st_pop3 && is_interrupt_return_op_q) |=> ie_q == $past(ie_q))
    else $error("int enable changed");
  index_load_a: assert property (@(posedge clock) disable iff (!rstn)
    index_we |=> index_value == $past(index_wdata))
    else $error("index load failed");
  // main scenarios reached
  call_c: cover property (@(posedge clock) take && op == seq_pkg::op_call);
  irq_c: cover property (@(posedge clock) take && op == seq_pkg::op_irq);
  ret_c: cover property (@(posedge clock) state_q == st_pop3 && !is_interrupt_return_op_q);
  interrupt_return_op_c: cover property (@(posedge clock) state_q == st_pop3 && is_interrupt_return_op_q);
  page_c: cover property (@(posedge clock) take && op == seq_pkg::op_page);
endmodule : program_sequencer_stack

// ===== rtl/seq_pkg.sv
package seq_pkg;
  localparam int pc_w = 14;
  localparam int lo_w = 8;
  localparam int hi_w = 6;
  localparam logic [13:0] pc_reset = 14'h0000;
  localparam logic [7:0] sp_reset = 8'h00;
  localparam logic [7:0] one_b = 8'h01;
  localparam logic [5:0] one_p = 6'h01;
  // first saved byte: carry, zero, upper counter bits
  localparam int b1_carry = 7;
  localparam int b1_zero = 6;

  typedef enum logic [2:0] {
    op_none, op_step, op_page, op_call, op_irq, op_ret, op_interrupt_return_op, op_jump
  } seq_op_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ram_req_t;

  typedef struct packed {
    logic carry;
    logic zero;
  } flags_t;
endpackage : seq_pkg

// ===== rtl/ret_stack_ptr.sv
`timescale 1ns/1ns
module ret_stack_ptr (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // controls
  input wire logic inc,
  input wire logic dec,
  input wire logic load,
  input wire logic [7:0] load_val,
  // state
  output logic [7:0] sp
);
  // plain 8-bit arithmetic, so wrap is free
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sp <= seq_pkg::sp_reset;
    end else if (load) begin
      sp <= load_val;
    end else if (inc) begin
      sp <= sp + seq_pkg::one_b;
    end else if (dec) begin
      sp <= sp - seq_pkg::one_b;
    end
  end
endmodule : ret_stack_ptr

// ===== rtl/index_reg.sv
`timescale 1ns/1ns
module index_reg (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // write port
  input wire logic we,
  input wire logic [7:0] wdata,
  input wire logic [7:0] base,
  // outputs
  output logic [7:0] value,
  output logic [7:0] eff_addr
);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      value <= 8'h00;
    end else if (we) begin
      value <= wdata;
    end
  end

  // indexed address is base plus index, wrapping within data ram
  assign eff_addr = base + value;
endmodule : index_reg

// ===== bench/data_ram_model.sv
`timescale 1ns/1ns
module data_ram_model (
  // clock
  input wire logic clock,
  // request from the sequencer
  input seq_pkg::ram_req_t ram_req,
  // read data, valid one cycle after a read request
  output logic [7:0] ram_rdata
);
  logic [7:0] mem [256];
  initial ram_rdata = 8'h00;
  // outside a read cycle the data toggles, so a late capture shows up as a wrong byte
  always @(posedge clock) begin
    if (ram_req.we) mem[ram_req.addr] <= ram_req.wdata;
    ram_rdata <= ram_req.re ? mem[ram_req.addr] : ~ram_rdata;
  end
endmodule : data_ram_model

// ===== bench/test_program_sequencer_stack.sv
`timescale 1ns/1ns
module test_program_sequencer_stack;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic op_valid = 1'b0;
  seq_pkg::seq_op_t op = seq_pkg::op_none;
  logic [13:0] jump_target = 14'h0000;
  logic [2:0] step_bytes = 3'h0;
  seq_pkg::flags_t flags_in = 2'h0;
  logic sp_load = 1'b0;
  logic [7:0] accumulator = 8'h00;
  logic index_we = 1'b0;
  logic [7:0] index_wdata = 8'h00;
  logic [7:0] index_base = 8'h00;
  logic op_ready;
  seq_pkg::flags_t flags_out;
  logic [7:0] index_value;
  logic [7:0] index_addr;
  seq_pkg::ram_req_t ram_req;
  logic [7:0] ram_rdata;
  logic [13:0] fetch_pointer;
  logic [7:0] return_stack_pointer;
  logic int_enable;
  seq_pkg::flags_t f;
  int err_total = 0;
  int comparisons = 0;

  always #2 clock = ~clock;

  program_sequencer_stack i_dut (.clock(clock), .rstn(rstn), .op_valid(op_valid), .op(op),
    .jump_target(jump_target), .step_bytes(step_bytes), .op_ready(op_ready), .flags_in(flags_in),
    .flags_out(flags_out), .sp_load(sp_load), .accumulator(accumulator), .index_we(index_we),
    .index_wdata(index_wdata), .index_base(index_base), .index_value(index_value),
    .index_addr(index_addr), .ram_req(ram_req), .ram_rdata(ram_rdata),
    .fetch_pointer(fetch_pointer), .return_stack_pointer(return_stack_pointer),
    .int_enable(int_enable));

  data_ram_model i_ram (.clock(clock), .ram_req(ram_req), .ram_rdata(ram_rdata));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // hold the request until taken, then wait out the busy window; fs is flags when idle again
  task automatic run_op(input seq_pkg::seq_op_t o, input logic [13:0] t, output seq_pkg::flags_t fs);
    int n;
    @(posedge clock);
    op <= o;
    jump_target <= t;
    op_valid <= 1'b1;
    n = 0;
    #1;
    // ready is looked at away from the edge; the next edge then takes the request
    while (op_ready !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    @(posedge clock);
    op_valid <= 1'b0;
    op <= seq_pkg::op_none;
    #1;
    while (op_ready !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 20) begin
      err_total++;
      final_report();
    end
    fs = flags_out;
    repeat (2) @(posedge clock);
    #1;
  endtask : run_op

  task automatic test_reset;
    check(fetch_pointer, 16'h0000, "reset pointer");
    check(return_stack_pointer, 16'h0000, "reset stack ptr");
    check(int_enable, 16'h0000, "reset int enable");
  endtask : test_reset

  // low byte wraps inside the page, page op moves the upper bits
  task automatic test_paging;
    step_bytes <= 3'h3;
    run_op(seq_pkg::op_jump, 14'h01FE, f);
    run_op(seq_pkg::op_step, 14'h0000, f);
    check(fetch_pointer, 16'h0101, "step no carry");
    run_op(seq_pkg::op_page, 14'h0000, f);
    check(fetch_pointer, 16'h0201, "page advance");
  endtask : test_paging

  task automatic test_push;
    flags_in <= 2'h2;
    run_op(seq_pkg::op_call, 14'h0345, f);
    check(i_ram.mem[0], 16'h0082, "call byte1");
    check(i_ram.mem[1], 16'h0001, "call byte2");
    check(return_stack_pointer, 16'h0002, "call sp");
    check(fetch_pointer, 16'h0345, "call target");
    flags_in <= 2'h1;
    run_op(seq_pkg::op_irq, 14'h0004, f);
    check(i_ram.mem[2], 16'h0043, "irq byte1");
    check(i_ram.mem[3], 16'h0045, "irq byte2");
    check(return_stack_pointer, 16'h0004, "irq sp");
    check(int_enable, 16'h0000, "irq disables");
  endtask : test_push

  task automatic test_pop;
    flags_in <= 2'h0;
    run_op(seq_pkg::op_interrupt_return_op, 14'h0000, f);
    check(f, 16'h0001, "interrupt_return_op flags");
    check(fetch_pointer, 16'h0345, "interrupt_return_op pointer");
    check(return_stack_pointer, 16'h0002, "interrupt_return_op sp");
    check(int_enable, 16'h0001, "interrupt_return_op enables");
    flags_in <= 2'h3;
    run_op(seq_pkg::op_ret, 14'h0000, f);
    check(f, 16'h0003, "ret keeps flags");
    check(fetch_pointer, 16'h0201, "ret pointer");
    check(return_stack_pointer, 16'h0000, "ret sp");
  endtask : test_pop

  // a call from the top of the stack must wrap to address zero
  task automatic test_sp_wrap;
    @(posedge clock);
    accumulator <= 8'hFF;
    sp_load <= 1'b1;
    @(posedge clock);
    sp_load <= 1'b0;
    @(posedge clock);
    #1;
    check(return_stack_pointer, 16'h00FF, "sp load");
    run_op(seq_pkg::op_call, 14'h0010, f);
    check(i_ram.mem[255], 16'h00C2, "wrap byte1");
    check(return_stack_pointer, 16'h0001, "wrap sp");
    check(i_ram.mem[0], 16'h0001, "wrap byte2");
    run_op(seq_pkg::op_irq, 14'h0004, f);
    check(int_enable, 16'h0000, "irq disables after interrupt_return_op");
    check(i_ram.mem[1], 16'h00C0, "irq byte1 after call");
    check(i_ram.mem[2], 16'h0010, "irq byte2 after call");
  endtask : test_sp_wrap

  task automatic test_index;
    @(posedge clock);
    index_we <= 1'b1;
    index_wdata <= 8'h03;
    index_base <= 8'h10;
    @(posedge clock);
    index_we <= 1'b0;
    @(posedge clock);
    #1;
    check(index_value, 16'h0003, "index value");
    check(index_addr, 16'h0013, "indexed address");
  endtask : test_index

  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    #1;
    test_reset();
    test_paging();
    test_push();
    test_pop();
    test_sp_wrap();
    test_index();
    final_report();
  end
endmodule : test_program_sequencer_stack
